// file: logic/rvss_map.svh
// register offsets, field positions and reset values of the rail bank
`ifndef RVSS_MAP_SVH
`define RVSS_MAP_SVH
`define RVSS_OFF_SHUTDOWN 8'h91
`define RVSS_OFF_RAIL1_SLEEP 8'h92
`define RVSS_OFF_RAIL2_SLEEP 8'h93
`define RVSS_OFF_RAIL4_VSEL 8'h94
`define RVSS_SHUTDOWN_BIT 0
`define RVSS_CODE_MSB 7
`define RVSS_CODE_LSB 1
`define RVSS_FLAG_BIT 0
`define RVSS_RST_SHUTDOWN 8'h00
`define RVSS_RST_RAIL 8'h00
`endif

// file: logic/rvss_pkg.sv
// types shared by the rail voltage and sleep bank
`default_nettype none
package rvss_pkg;
    typedef logic [6:0] rvss_code_t;
    typedef logic [7:0] rvss_byte_t;
endpackage : rvss_pkg
`default_nettype wire

// file: logic/rvss_code_select.sv
// sleep or normal code selection for one regulator
`default_nettype none
module rvss_code_select (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // controls
    input wire logic sleep_enable,
    input wire logic sleep_pin_sync,
    input wire rvss_pkg::rvss_code_t normal_code,
    input wire rvss_pkg::rvss_code_t sleep_code,
    // result
    output logic sleep_active,
    output rvss_pkg::rvss_code_t active_code
);
    // sleep only when enabled and the assigned pin is low
    always_comb begin
        sleep_active = sleep_enable && !sleep_pin_sync;
        active_code = sleep_active ? sleep_code : normal_code;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    // a disabled rail never leaves its normal code, whatever the pin does
    property p_sel;
        @(posedge sys_clk) disable iff (!arst_n)
        !sleep_enable |-> active_code == normal_code && !sleep_active;
    endproperty
    a_sel: assert property (p_sel)
        else $error("sleep code used while sleep disabled");
    // enabled and pin low gives the sleep code
    property p_slp;
        @(posedge sys_clk) disable iff (!arst_n)
        sleep_enable && !sleep_pin_sync |-> active_code == sleep_code;
    endproperty
    a_slp: assert property (p_slp)
        else $error("sleep code not used");
    // enabled but pin high keeps the normal code
    property p_wake;
        @(posedge sys_clk) disable iff (!arst_n)
        sleep_enable && sleep_pin_sync |->
            active_code == normal_code && !sleep_active;
    endproperty
    a_wake: assert property (p_wake)
        else $error("sleep code used with pin high");
endmodule : rvss_code_select
`default_nettype wire

// file: logic/rvss_regs.sv
// rail voltage, sleep and forced shutdown register bank
`include "rvss_map.svh"
`default_nettype none
module rvss_regs #(
    // factory pin assignment: 0 selects input one, 1 input two
    parameter logic RAIL1_PIN_SEL = 1'b0,
    parameter logic RAIL2_PIN_SEL = 1'b1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // register port from the serial slave, one byte per strobe
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_wr_ack,
    // sleep pins, asynchronous
    input wire logic sleep_input_one,
    input wire logic sleep_input_two,
    // normal codes of rails one and two from elsewhere
    input wire rvss_pkg::rvss_code_t rail1_normal_voltage_code,
    input wire rvss_pkg::rvss_code_t rail2_normal_voltage_code,
    // regulator controls
    output rvss_pkg::rvss_code_t rail1_active_code,
    output rvss_pkg::rvss_code_t rail2_active_code,
    output logic rail1_sleep_active,
    output logic rail2_sleep_active,
    output rvss_pkg::rvss_code_t rail4_voltage_code,
    output logic rail4_active_slew,
    output logic rail4_passive_decay,
    // device wide shutdown pulse
    output logic shutdown_pulse
);
    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [1:0] s1;     // pin one synchroniser
        logic [1:0] s2;     // pin two synchroniser
        logic [7:0] r1;     // rail one sleep control
        logic [7:0] r2;     // rail two sleep control
        logic [7:0] r4;     // rail four voltage select
        logic sd;           // shutdown requested, shown for one cycle
        logic [7:0] rd;     // read data
    } rvss_state_t;

    rvss_state_t st_reg;
    rvss_state_t st_next;
    logic wr_sd; // write of one to shutdown bit
    logic pin1;
    logic pin2;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_next = st_reg;
        // two flops per pin: only the second is read, so a metastable
        // first stage never reaches the code selectors
        st_next.s1 = {st_reg.s1[0], sleep_input_one};
        st_next.s2 = {st_reg.s2[0], sleep_input_two};
        wr_sd = reg_wr && reg_addr == `RVSS_OFF_SHUTDOWN &&
            reg_wdata[`RVSS_SHUTDOWN_BIT];
        // self clearing: set only in the write cycle
        st_next.sd = wr_sd;
        if (st_reg.sd) begin
            // shutdown returns every register to its default
            st_next.r1 = `RVSS_RST_RAIL;
            st_next.r2 = `RVSS_RST_RAIL;
            st_next.r4 = `RVSS_RST_RAIL;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `RVSS_OFF_RAIL1_SLEEP: st_next.r1 = reg_wdata;
                `RVSS_OFF_RAIL2_SLEEP: st_next.r2 = reg_wdata;
                `RVSS_OFF_RAIL4_VSEL: st_next.r4 = reg_wdata;
                default: ; // shutdown and unmapped hold no stored bits
            endcase
        end
        // reads: shutdown bit never stored, reserved read zero
        st_next.rd = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `RVSS_OFF_SHUTDOWN: begin
                    st_next.rd = `RVSS_RST_SHUTDOWN;
                end
                `RVSS_OFF_RAIL1_SLEEP: st_next.rd = st_reg.r1;
                `RVSS_OFF_RAIL2_SLEEP: st_next.rd = st_reg.r2;
                `RVSS_OFF_RAIL4_VSEL: st_next.rd = st_reg.r4;
                default: st_next.rd = 8'h00;
            endcase
        end
    end

    // registers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    // factory fixed routing, no register can change it
    assign pin1 = RAIL1_PIN_SEL ? st_reg.s2[1] : st_reg.s1[1];
    assign pin2 = RAIL2_PIN_SEL ? st_reg.s2[1] : st_reg.s1[1];
    // no ack for the shutdown byte; other writes are acknowledged
    assign reg_wr_ack = reg_wr && !wr_sd;
    assign reg_rdata = st_reg.rd;
    assign shutdown_pulse = st_reg.sd;
    assign rail4_voltage_code = st_reg.r4[`RVSS_CODE_MSB:`RVSS_CODE_LSB];
    assign rail4_passive_decay = st_reg.r4[`RVSS_FLAG_BIT];
    assign rail4_active_slew = !st_reg.r4[`RVSS_FLAG_BIT];

    rvss_code_select u_sel1 (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .sleep_enable(st_reg.r1[`RVSS_FLAG_BIT]),
        .sleep_pin_sync(pin1),
        .normal_code(rail1_normal_voltage_code),
        .sleep_code(st_reg.r1[`RVSS_CODE_MSB:`RVSS_CODE_LSB]),
        .sleep_active(rail1_sleep_active),
        .active_code(rail1_active_code)
    );
    rvss_code_select u_sel2 (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .sleep_enable(st_reg.r2[`RVSS_FLAG_BIT]),
        .sleep_pin_sync(pin2),
        .normal_code(rail2_normal_voltage_code),
        .sleep_code(st_reg.r2[`RVSS_CODE_MSB:`RVSS_CODE_LSB]),
        .sleep_active(rail2_sleep_active),
        .active_code(rail2_active_code)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks
    // a request gives one pulse, unless it is renewed at once
    property p_sd;
        @(posedge sys_clk) disable iff (!arst_n)
        wr_sd |=> shutdown_pulse ##1 (!shutdown_pulse || $past(wr_sd));
    endproperty
    a_sd: assert property (p_sd)
        else $error("shutdown pulse wrong");
    // the cycle after the pulse every stored register is at default
    property p_sclr;
        @(posedge sys_clk) disable iff (!arst_n)
        shutdown_pulse |=> st_reg.r1 == `RVSS_RST_RAIL &&
            st_reg.r2 == `RVSS_RST_RAIL && st_reg.r4 == `RVSS_RST_RAIL;
    endproperty
    a_sclr: assert property (p_sclr)
        else $error("regs not reset");

    // without a fresh request the pulse drops by itself
    property p_self;
        @(posedge sys_clk) disable iff (!arst_n)
        shutdown_pulse && !wr_sd |=> !shutdown_pulse;
    endproperty
    a_self: assert property (p_self)
        else $error("shutdown pulse stuck");

    // the shutdown byte goes unanswered
    property p_nack;
        @(posedge sys_clk) disable iff (!arst_n)
        wr_sd |-> !reg_wr_ack;
    endproperty
    a_nack: assert property (p_nack)
        else $error("shutdown acked");
    // every write elsewhere is acknowledged in its own cycle
    property p_ack;
        @(posedge sys_clk) disable iff (!arst_n)
        reg_wr && reg_addr != `RVSS_OFF_SHUTDOWN |-> reg_wr_ack;
    endproperty
    a_ack: assert property (p_ack)
        else $error("write not acked");

    // the shutdown register always reads as zero
    property p_rd91;
        @(posedge sys_clk) disable iff (!arst_n)
        reg_rd && reg_addr == `RVSS_OFF_SHUTDOWN |=>
            reg_rdata == `RVSS_RST_SHUTDOWN;
    endproperty
    a_rd91: assert property (p_rd91)
        else $error("shutdown reads nonzero");

    // sleep codes land in the upper seven bits of their control byte
    property p_wr92;
        @(posedge sys_clk) disable iff (!arst_n)
        reg_wr && reg_addr == `RVSS_OFF_RAIL1_SLEEP && !shutdown_pulse |=>
            st_reg.r1[`RVSS_CODE_MSB:`RVSS_CODE_LSB] ==
            $past(reg_wdata[`RVSS_CODE_MSB:`RVSS_CODE_LSB]);
    endproperty
    a_wr92: assert property (p_wr92)
        else $error("rail1 sleep code lost");
    property p_wr93;
        @(posedge sys_clk) disable iff (!arst_n)
        reg_wr && reg_addr == `RVSS_OFF_RAIL2_SLEEP && !shutdown_pulse |=>
            st_reg.r2[`RVSS_CODE_MSB:`RVSS_CODE_LSB] ==
            $past(reg_wdata[`RVSS_CODE_MSB:`RVSS_CODE_LSB]);
    endproperty
    a_wr93: assert property (p_wr93)
        else $error("rail2 sleep code lost");

    // a write in the pulse cycle is lost, so it is left out here
    property p_wr94;
        @(posedge sys_clk) disable iff (!arst_n)
        reg_wr && reg_addr == `RVSS_OFF_RAIL4_VSEL && !shutdown_pulse |=>
            rail4_voltage_code ==
            $past(reg_wdata[`RVSS_CODE_MSB:`RVSS_CODE_LSB]);
    endproperty
    a_wr94: assert property (p_wr94)
        else $error("rail4 code lost");

    // decay flag follows the written bit; slew is its complement
    property p_dec;
        @(posedge sys_clk) disable iff (!arst_n)
        reg_wr && reg_addr == `RVSS_OFF_RAIL4_VSEL && !shutdown_pulse |=>
            rail4_passive_decay == $past(reg_wdata[`RVSS_FLAG_BIT]) &&
            rail4_active_slew == !$past(reg_wdata[`RVSS_FLAG_BIT]);
    endproperty
    a_dec: assert property (p_dec)
        else $error("decay mode wrong");
endmodule : rvss_regs
`default_nettype wire

// file: tb/rvss_host_model.sv
// host side model that drives the register strobe port
`default_nettype none
module rvss_host_model (
    // clock
    input wire logic sys_clk,
    // register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic reg_wr_ack,
    input wire logic shutdown_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // one write; a missing ack is noted, never retried
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
            output logic ack, output logic pls);
        @(negedge sys_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge sys_clk);
        ack = reg_wr_ack;
        #1 pls = shutdown_pulse;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        // released data must not keep the old value
        reg_wdata = ~d;
    endtask : wr
    // one read strobe, data is checked by the bench monitor
    task automatic rd(input logic [7:0] a);
        @(negedge sys_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask : rd
endmodule : rvss_host_model
`default_nettype wire

// file: tb/rail_voltage_sleep_shutdown_regs_tb_top.sv
// self-checking bench of the rail voltage and sleep bank
`default_nettype none
module rail_voltage_sleep_shutdown_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, arst_n = 1'b0, p1 = 1'b0, p2 = 1'b0;
    logic reg_wr, reg_rd, ack, pls, s1, s2, dc, sl, got;
    // host's view of a write, and the expected sleep state
    logic ack_s, pls_s, exp_slp;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, exp_q[$];
    rvss_pkg::rvss_code_t n1 = 7'h00, n2 = 7'h00, c, a1, a2, v4;
    int n_fail = 0, num_checks = 0, i;
    always #10 sys_clk = ~sys_clk;
    rvss_regs DUT (.sys_clk(sys_clk), .arst_n(arst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_wr_ack(ack), .sleep_input_one(p1),
        .sleep_input_two(p2), .rail1_normal_voltage_code(n1),
        .rail2_normal_voltage_code(n2), .rail1_active_code(a1),
        .rail2_active_code(a2), .rail1_sleep_active(s1),
        .rail2_sleep_active(s2), .rail4_voltage_code(v4),
        .rail4_active_slew(sl), .rail4_passive_decay(dc),
        .shutdown_pulse(pls));
    rvss_host_model HOST (.sys_clk(sys_clk), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr_ack(ack), .shutdown_pulse(pls));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        num_checks++;
        if (seen !== want) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen,
                want);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks %0d, failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    // note the expected byte, then issue the read
    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        HOST.rd(a);
    endtask : rdx
    // read data stands the cycle after the strobe edge
    always @(posedge sys_clk) begin
        got = reg_rd;
        #1;
        if (got && exp_q.size() > 0) chk(reg_rdata, exp_q.pop_front());
    end
    // watchdog, far beyond the hundred or so cycles of the run
    initial begin
        #200us;
        n_fail++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h22bf));
        n1 = 7'($urandom);
        n2 = 7'($urandom);
        repeat (3) @(negedge sys_clk);
        arst_n = 1'b1;
        // defaults, reserved and unmapped places read zero
        for (i = 8'h90; i < 8'h96; i++) rdx(8'(i), 8'h00);
        // each rail, enable and pin level; other pin opposite
        for (i = 0; i < 8; i++) begin
            c = 7'($urandom);
            HOST.wr(8'h92 + 8'(i[2]), {c, i[0]}, ack_s, pls_s);
            chk({7'h00, ack_s}, 8'h01);
            rdx(8'h92 + 8'(i[2]), {c, i[0]});
            p1 = i[2] ? ~i[1] : i[1];
            p2 = i[2] ? i[1] : ~i[1];
            repeat (4) @(negedge sys_clk);
            exp_slp = i[0] & ~i[1];
            if (!i[2]) chk(8'(a1), 8'(exp_slp ? c : n1));
            if (i[2]) chk(8'(a2), 8'(exp_slp ? c : n2));
            chk(8'(i[2] ? s2 : s1), 8'(exp_slp));
        end
        // rail four code with both decay choices
        for (i = 0; i < 2; i++) begin
            c = 7'($urandom);
            HOST.wr(8'h94, {c, i[0]}, ack_s, pls_s);
            chk({7'h00, ack_s}, 8'h01);
            chk(8'(v4), 8'(c));
            chk({6'h00, dc, sl}, {6'h00, i[0], ~i[0]});
        end
        // reserved bits only: acked, no shutdown
        HOST.wr(8'h91, 8'hfe, ack_s, pls_s);
        chk({6'h00, ack_s, pls_s}, 8'h02);
        rdx(8'h91, 8'h00);
        // shutdown: no ack, pulse, bank cleared
        HOST.wr(8'h91, 8'h01, ack_s, pls_s);
        chk({6'h00, ack_s, pls_s}, 8'h01);
        // pulse still up at this falling edge, gone one cycle on
        chk({7'h00, pls}, 8'h01);
        @(negedge sys_clk);
        chk({7'h00, pls}, 8'h00);
        // bank back at defaults: slew mode, rail one normal code, code zero
        chk({6'h00, dc, sl}, 8'h01);
        chk(8'(a1), 8'(n1));
        chk(8'(v4), 8'h00);
        rdx(8'h91, 8'h00);
        for (i = 8'h92; i < 8'h95; i++) rdx(8'(i), 8'h00);
        repeat (3) @(negedge sys_clk);
        end_of_test();
    end
endmodule : rail_voltage_sleep_shutdown_regs_tb_top
`default_nettype wire
